// *** rtl/dpm_err_tunnel.sv ***
// host port error flags, error address log, pin config and access tunnel
//
// Overview of operation
// - error clear bits 5..1, reset zero
// - writing one clears flag, zero keeps it
// - error address holds 17-bit host address
// - only read, write, timeout errors freeze address
// - bus conflicts never freeze the address
// - no logged flag: address follows every access
// - clear-on-read bit makes reads clear flags
// - read/write error blocks internal area accesses
// - bit 7 fast interrupt drive when active
// - bit 6 fast interrupt polarity, high active
// - bit 5 normal interrupt drive when active
// - bit 4 normal interrupt polarity, high active
// - bits 2..0 select pins as gpio
// - tunnel is 64-byte window, sixteen words
// - word 15 holds internal base, others data
// - base bits 5..2 rotate word mapping
// - internal address from base plus masked sum
// - tunnel hit when address>>6 equals base
// - no read-ahead, narrow writes collected first
// - tunnel beats config window beats windows
// - base internally writable, host write protectable
// - data protect makes words 0..14 read-only
`timescale 1ns/10ps
`default_nettype none
module dpm_err_tunnel (
   input  wire logic                          clk_i,
   input  wire logic                          resetn_i,
   input  wire logic [31:0]                   reg_addr_i,
   input  wire logic                          reg_wr_i,
   input  wire logic                          reg_rd_i,
   input  wire logic [31:0]                   reg_wdata_i,
   output logic      [31:0]                   reg_rdata_o,
   input  wire dpm_err_tunnel_pkg::host_req_t host_req_i,
   output logic                               host_busy_o,
   output logic                               host_ack_o,
   output logic      [31:0]                   host_rdata_o,
   output logic                               window_hit_o,
   output dpm_err_tunnel_pkg::int_req_t       int_req_o,
   input  wire logic                          int_ack_i,
   input  wire logic [31:0]                   int_rdata_i,
   input  wire logic [5:1]                    err_set_i,
   output logic      [5:1]                    err_flags_o,
   input  wire logic                          fast_interrupt_i,
   input  wire logic                          normal_interrupt_i,
   output logic                               fast_int_pin_o,
   output logic                               fast_int_pin_oe_n_o,
   output logic                               normal_int_pin_o,
   output logic                               normal_int_pin_oe_n_o,
   output logic                               fast_int_pin_as_gpio_o,
   output logic                               normal_int_pin_as_gpio_o,
   output logic                               ready_pin_as_gpio_o
);
   import dpm_err_tunnel_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // reset release and state
   logic [1:0]  rst_sync_ff;
   logic        rst_n;
   st_t         st_ff;
   st_t         nxt_st;
   logic        reg_page_c;
   logic        accept_c;
   logic        tun_hit_c;
   logic        cfg_hit_c;
   logic        last_word_c;
   logic        logged_c;
   logic        blocked_c;
   logic [5:0]  tun_ofs_c;
   logic [31:0] tun_addr_c;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   ////////////////////////////////////////////////////////////////////////////////
   // register helpers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old & ~m) | (wd & m);
   endfunction

   function automatic logic [31:0] rd_reg(input st_t s, input logic [7:0] off);
      logic [31:0] d;
      d = '0;
      case (off)
         ADR_ERR_CLR[7:0]:  d[5:1] = s.flags;
         ADR_ERR_ADDR[7:0]: d[16:0] = s.err_addr;
         ADR_MISC[7:0]:     d[MISC_COR] = s.cor;
         ADR_PIN[7:0]:      d[7:0] = s.pincfg;
         ADR_TUN[7:0]:      d = {15'h0, s.tun_base, 3'h0, s.tun_en, s.wp_itb, s.wp_data};
         ADR_ITB[7:0]:      d = {s.itb, s.wp_itb, s.wp_data};
         default:           d = '0;
      endcase
      return d;
   endfunction

   function automatic st_t wr_reg(input st_t s, input logic [7:0] off,
                                  input logic [31:0] wd, input logic [3:0] be);
      st_t         n;
      logic [31:0] v;
      logic [31:0] w1;
      n = s;
      v = merge(rd_reg(s, off), wd, be);
      w1 = merge(32'h0, wd, be);
      case (off)
         ADR_ERR_CLR[7:0]: n.flags = s.flags & ~w1[5:1];
         ADR_MISC[7:0]:    n.cor = v[MISC_COR];
         ADR_PIN[7:0]:     n.pincfg = v[7:0] & PIN_WR_MASK;
         ADR_TUN[7:0]: begin
            n.tun_base = v[TUN_BASE_LSB +: TUN_BASE_W];
            n.tun_en = v[TUN_EN];
            n.wp_itb = v[TUN_WP_ITB];
            n.wp_data = v[TUN_WP_DATA];
         end
         ADR_ITB[7:0]:     n.itb = v[31:2];
         default:          n = s;
      endcase
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // address decode
   assign reg_page_c = (reg_addr_i[31:8] == ADR_ERR_CLR[31:8]);
   assign accept_c = (st_ff.state == idle_s) && host_req_i.valid;
   assign tun_hit_c = st_ff.tun_en
                      && (host_req_i.addr[16:6] == st_ff.tun_base);
   assign cfg_hit_c = !tun_hit_c && (host_req_i.addr < CFG_WIN_END);
   assign last_word_c = (host_req_i.addr[5:2] == TUN_LAST_WORD);
   assign logged_c = |(st_ff.flags & FLG_LOG_MASK);
   assign blocked_c = st_ff.flags[FLG_RD] | st_ff.flags[FLG_WR];
   assign tun_ofs_c = (host_req_i.addr[5:0] + {st_ff.itb[5:2], 2'h0}) & TUN_OFS_MASK;
   assign tun_addr_c = {st_ff.itb[31:6], tun_ofs_c};

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic [3:0]  cbe;
      logic [31:0] itb_m;
      cbe = 4'h0;
      itb_m = 32'h0;
      nxt_st = st_ff;
      nxt_st.host_ack = 1'b0;
      nxt_st.win_hit = 1'b0;
      if (reg_wr_i && reg_page_c) begin
         nxt_st = wr_reg(nxt_st, reg_addr_i[7:0], reg_wdata_i, 4'hf);
      end
      if (reg_rd_i) begin
         nxt_st.reg_rdata = reg_page_c ? rd_reg(st_ff, reg_addr_i[7:0]) : 32'h0;
         if (reg_page_c && reg_addr_i[7:0] == ADR_ERR_CLR[7:0] && st_ff.cor) begin
            nxt_st.flags = FLG_RST;
         end
      end
      case (st_ff.state)
         idle_s: begin
            if (accept_c) begin
               if (!logged_c) begin
                  nxt_st.err_addr = host_req_i.addr;
               end
               nxt_st.host_rdata = 32'h0;
               if (tun_hit_c && last_word_c) begin
                  nxt_st.host_ack = 1'b1;
                  if (!host_req_i.write) begin
                     nxt_st.host_rdata = {st_ff.itb, st_ff.wp_itb, st_ff.wp_data};
                  end else if (!st_ff.wp_itb) begin
                     itb_m = merge({st_ff.itb, 2'h0}, host_req_i.wdata, host_req_i.be);
                     nxt_st.itb = itb_m[31:2];
                  end
               end else if (tun_hit_c) begin
                  if (blocked_c || (host_req_i.write && st_ff.wp_data)) begin
                     nxt_st.host_ack = 1'b1;
                  end else if (host_req_i.write) begin
                     cbe = (st_ff.coll_addr == tun_addr_c) ? st_ff.coll_be : 4'h0;
                     nxt_st.coll_data = merge(st_ff.coll_data, host_req_i.wdata,
                                              host_req_i.be);
                     nxt_st.coll_addr = tun_addr_c;
                     nxt_st.coll_be = cbe | host_req_i.be;
                     if (&(cbe | host_req_i.be)) begin
                        nxt_st.coll_be = 4'h0;
                        nxt_st.ireq = '{1'b1, 1'b1, tun_addr_c, 4'hf, nxt_st.coll_data};
                        nxt_st.state = wait_s;
                     end else begin
                        nxt_st.host_ack = 1'b1;
                     end
                  end else begin
                     nxt_st.ireq = '{1'b1, 1'b0, tun_addr_c, host_req_i.be, 32'h0};
                     nxt_st.state = wait_s;
                  end
               end else if (cfg_hit_c) begin
                  nxt_st.host_ack = 1'b1;
                  if (host_req_i.write) begin
                     if (!(host_req_i.addr[7:0] == ADR_ITB[7:0] && st_ff.wp_itb)) begin
                        nxt_st = wr_reg(nxt_st, host_req_i.addr[7:0], host_req_i.wdata,
                                        host_req_i.be);
                     end
                  end else begin
                     nxt_st.host_rdata = rd_reg(st_ff, host_req_i.addr[7:0]);
                     if (host_req_i.addr[7:0] == ADR_ERR_CLR[7:0] && st_ff.cor) begin
                        nxt_st.flags = FLG_RST;
                     end
                  end
               end else if (blocked_c) begin
                  nxt_st.host_ack = 1'b1;
               end else begin
                  nxt_st.win_hit = 1'b1;
               end
            end
         end
         wait_s: begin
            if (int_ack_i) begin
               nxt_st.ireq.valid = 1'b0;
               nxt_st.host_ack = 1'b1;
               nxt_st.state = idle_s;
               if (!st_ff.ireq.write) begin
                  nxt_st.host_rdata = int_rdata_i;
               end
            end
         end
         default: nxt_st.state = idle_s;
      endcase
      nxt_st.flags = nxt_st.flags | err_set_i;
      // interrupt pins
      nxt_st.fast_pin = nxt_st.pincfg[PIN_FAST_INT_POLARITY] ? fast_interrupt_i
                                                  : !fast_interrupt_i;
      nxt_st.fast_oe_n = nxt_st.pincfg[PIN_FIQ_GPIO]
                         | (nxt_st.pincfg[PIN_FIQ_DRV] & !fast_interrupt_i);
      nxt_st.norm_pin = nxt_st.pincfg[PIN_NORMAL_INT_POLARITY] ? normal_interrupt_i
                                                  : !normal_interrupt_i;
      nxt_st.norm_oe_n = nxt_st.pincfg[PIN_IRQ_GPIO]
                         | (nxt_st.pincfg[PIN_IRQ_DRV] & !normal_interrupt_i);
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.flags <= FLG_RST;
         st_ff.err_addr <= ERR_ADDR_RST;
         st_ff.cor <= MISC_COR_RST;
         st_ff.pincfg <= PIN_RST;
         st_ff.tun_base <= TUN_BASE_RST;
         st_ff.wp_data <= TUN_WP_DATA_RST;
         st_ff.fast_oe_n <= 1'b1;
         st_ff.norm_oe_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign reg_rdata_o = st_ff.reg_rdata;
   assign host_busy_o = (st_ff.state != idle_s);
   assign host_ack_o = st_ff.host_ack;
   assign host_rdata_o = st_ff.host_rdata;
   assign window_hit_o = st_ff.win_hit;
   assign int_req_o = st_ff.ireq;
   assign err_flags_o = st_ff.flags;
   assign fast_int_pin_o = st_ff.fast_pin;
   assign fast_int_pin_oe_n_o = st_ff.fast_oe_n;
   assign normal_int_pin_o = st_ff.norm_pin;
   assign normal_int_pin_oe_n_o = st_ff.norm_oe_n;
   assign fast_int_pin_as_gpio_o = st_ff.pincfg[PIN_FIQ_GPIO];
   assign normal_int_pin_as_gpio_o = st_ff.pincfg[PIN_IRQ_GPIO];
   assign ready_pin_as_gpio_o = st_ff.pincfg[PIN_RDY_GPIO];

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n);

   sequence clr_write_s;
      reg_wr_i && reg_page_c && reg_addr_i[7:0] == ADR_ERR_CLR[7:0];
   endsequence
   sequence tun_rd_s;
      accept_c && tun_hit_c && !last_word_c && !host_req_i.write && !blocked_c;
   endsequence
   sequence int_rd_issue_s;
      st_ff.ireq.valid && !st_ff.ireq.write && st_ff.state == wait_s;
   endsequence

   clear_one_a: assert property (
      clr_write_s ##0 (reg_wdata_i[FLG_RD] && !err_set_i[FLG_RD] && !host_req_i.valid)
      |=> !st_ff.flags[FLG_RD])
      else $error("read error flag not cleared by write of one");
   clear_zero_a: assert property (
      clr_write_s ##0 (!reg_wdata_i[FLG_WR] && st_ff.flags[FLG_WR] && !accept_c && !reg_rd_i)
      |=> st_ff.flags[FLG_WR])
      else $error("write error flag lost on write of zero");
   set_wins_a: assert property (err_set_i[FLG_RDY] |=> st_ff.flags[FLG_RDY])
      else $error("timeout flag event lost");
   addr_freeze_a: assert property (logged_c |=> $stable(st_ff.err_addr))
      else $error("error address changed while frozen");
   addr_track_a: assert property (
      accept_c && !logged_c |=> st_ff.err_addr == $past(host_req_i.addr))
      else $error("error address did not follow access");
   conflict_log_a: assert property (
      accept_c && !logged_c && err_set_i[FLG_RCF] && !(|(err_set_i & FLG_LOG_MASK))
      |=> st_ff.err_addr == $past(host_req_i.addr) && !logged_c)
      else $error("conflict froze error address");
   clr_read_a: assert property (
      reg_rd_i && reg_page_c && reg_addr_i[7:0] == ADR_ERR_CLR[7:0] && st_ff.cor
      && err_set_i == 5'h00 && !accept_c |=> st_ff.flags == 5'h00)
      else $error("clear on read failed");
   tun_rd_issue_a: assert property (tun_rd_s |=> int_rd_issue_s)
      else $error("tunnel read not issued");
   tun_addr_map_a: assert property (
      tun_rd_s |=> st_ff.ireq.addr[31:6] == $past(st_ff.itb[31:6])
      && st_ff.ireq.addr[5:0] == (($past(host_req_i.addr[5:0])
      + {$past(st_ff.itb[5:2]), 2'h0}) & TUN_OFS_MASK))
      else $error("tunnel internal address wrong");
   err_block_a: assert property (
      accept_c && blocked_c && !cfg_hit_c && !(tun_hit_c && last_word_c)
      |=> host_ack_o && !int_req_o.valid && !window_hit_o)
      else $error("access not ignored under error");
   data_prot_a: assert property (
      accept_c && tun_hit_c && !last_word_c && host_req_i.write && st_ff.wp_data
      |=> host_ack_o && !int_req_o.valid)
      else $error("protected tunnel write passed");
   fast_pol_a: assert property (
      !st_ff.pincfg[PIN_FAST_INT_POLARITY] && !reg_wr_i && !accept_c && fast_interrupt_i
      |=> !fast_int_pin_o)
      else $error("fast interrupt polarity wrong");
   win_hit_a: assert property (
      accept_c && !tun_hit_c && !cfg_hit_c && !blocked_c |=> window_hit_o && !host_ack_o)
      else $error("normal window access not flagged");
   itb_prot_a: assert property (
      accept_c && tun_hit_c && last_word_c && host_req_i.write && st_ff.wp_itb
      && !(reg_wr_i && reg_page_c) |=> $stable(st_ff.itb))
      else $error("protected tunnel base changed by host");
   gpio_oe_a: assert property (
      st_ff.pincfg[PIN_FIQ_GPIO] && !reg_wr_i && !accept_c |=> fast_int_pin_oe_n_o)
      else $error("gpio fast interrupt pin still driven");
   norm_drive_a: assert property (
      !st_ff.pincfg[PIN_IRQ_DRV] && !st_ff.pincfg[PIN_IRQ_GPIO] && !reg_wr_i && !accept_c
      |=> !normal_int_pin_oe_n_o)
      else $error("normal interrupt pin not always driven");
endmodule
`default_nettype wire

// *** rtl/dpm_err_tunnel_pkg.sv ***
// shared constants and types for the host error and tunnel block
package dpm_err_tunnel_pkg;
   // register addresses on the internal side
   localparam logic [31:0] ADR_ERR_CLR   = 32'h101c1220;
   localparam logic [31:0] ADR_ERR_ADDR  = 32'h101c1224;
   localparam logic [31:0] ADR_MISC      = 32'h101c1228;
   localparam logic [31:0] ADR_PIN       = 32'h101c122c;
   localparam logic [31:0] ADR_TUN       = 32'h101c1238;
   localparam logic [31:0] ADR_ITB       = 32'h101c123c;
   // host address space
   localparam int          HADDR_W       = 17;
   localparam logic [16:0] CFG_WIN_END   = 17'h00100;
   // error flag positions
   localparam int          FLG_RD        = 1;
   localparam int          FLG_WR        = 2;
   localparam int          FLG_RDY       = 3;
   localparam int          FLG_WCF       = 4;
   localparam int          FLG_RCF       = 5;
   localparam logic [5:1]  FLG_LOG_MASK  = 5'h07;
   localparam logic [5:1]  FLG_RST       = 5'h00;
   localparam logic [16:0] ERR_ADDR_RST  = 17'h00000;
   // special function config
   localparam int          MISC_COR      = 0;
   localparam logic        MISC_COR_RST  = 1'h0;
   // pin drive config
   localparam int          PIN_FIQ_DRV   = 7;
   localparam int          PIN_FAST_INT_POLARITY   = 6;
   localparam int          PIN_IRQ_DRV   = 5;
   localparam int          PIN_NORMAL_INT_POLARITY   = 4;
   localparam int          PIN_FIQ_GPIO  = 2;
   localparam int          PIN_IRQ_GPIO  = 1;
   localparam int          PIN_RDY_GPIO  = 0;
   localparam logic [7:0]  PIN_RST       = 8'ha7;
   localparam logic [7:0]  PIN_WR_MASK   = 8'hf7;
   // tunnel config
   localparam int          TUN_BASE_LSB  = 6;
   localparam int          TUN_BASE_W    = 11;
   localparam logic [10:0] TUN_BASE_RST  = 11'h004;
   localparam int          TUN_EN        = 2;
   localparam int          TUN_WP_ITB    = 1;
   localparam int          TUN_WP_DATA   = 0;
   localparam logic        TUN_WP_DATA_RST = 1'h1;
   localparam logic [5:0]  TUN_OFS_MASK  = 6'h3c;
   localparam logic [3:0]  TUN_LAST_WORD = 4'hf;

   typedef enum logic {idle_s, wait_s} fsm_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [16:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } host_req_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } int_req_t;

   typedef struct packed {
      fsm_t        state;
      logic [5:1]  flags;
      logic [16:0] err_addr;
      logic        cor;
      logic [7:0]  pincfg;
      logic [10:0] tun_base;
      logic        tun_en;
      logic        wp_itb;
      logic        wp_data;
      logic [31:2] itb;
      logic [31:0] coll_data;
      logic [3:0]  coll_be;
      logic [31:0] coll_addr;
      int_req_t    ireq;
      logic        host_ack;
      logic        win_hit;
      logic [31:0] host_rdata;
      logic [31:0] reg_rdata;
      logic        fast_pin;
      logic        fast_oe_n;
      logic        norm_pin;
      logic        norm_oe_n;
   } st_t;
endpackage

// *** verif/int_bus_responder.sv ***
// internal bus responder model answering tunnel accesses after a set delay
`timescale 1ns/10ps
`default_nettype none
module int_bus_responder (
   input  wire logic                         clk_i,
   input  wire logic                         resetn_i,
   input  wire dpm_err_tunnel_pkg::int_req_t int_req_i,
   input  wire logic [3:0]                   delay_i,
   output logic                              int_ack_o,
   output logic      [31:0]                  int_rdata_o,
   output logic      [31:0]                  last_addr_o,
   output logic      [31:0]                  last_wdata_o,
   output logic      [7:0]                   acc_count_o
);
   import dpm_err_tunnel_pkg::*;
   logic [3:0] wait_ff;
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         int_ack_o    <= 1'b0;
         wait_ff      <= 4'h0;
         int_rdata_o  <= 32'h0;
         last_addr_o  <= 32'h0;
         last_wdata_o <= 32'h0;
         acc_count_o  <= 8'h00;
      end else if (int_ack_o) begin
         int_ack_o   <= 1'b0;
         wait_ff     <= 4'h0;
         int_rdata_o <= ~int_rdata_o;
      end else if (int_req_i.valid && wait_ff == delay_i) begin
         int_ack_o    <= 1'b1;
         int_rdata_o  <= int_req_i.addr ^ 32'h0f0f0000;
         last_addr_o  <= int_req_i.addr;
         last_wdata_o <= int_req_i.write ? int_req_i.wdata : 32'h0;
         acc_count_o  <= acc_count_o + 8'h01;
      end else begin
         wait_ff     <= int_req_i.valid ? wait_ff + 4'h1 : 4'h0;
         int_rdata_o <= ~int_rdata_o;
      end
   end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the host error and tunnel block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import dpm_err_tunnel_pkg::*;
   logic        clk_i, resetn_i, reg_wr_i, reg_rd_i, int_ack_i, h, b;
   logic        host_busy_o, host_ack_o, window_hit_o, fast_interrupt_i, normal_interrupt_i;
   logic        fast_int_pin_o, fast_int_pin_oe_n_o, normal_int_pin_o, normal_int_pin_oe_n_o;
   logic        fast_int_pin_as_gpio_o, normal_int_pin_as_gpio_o, ready_pin_as_gpio_o;
   logic [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o, host_rdata_o, int_rdata_i, r, last_a, last_d;
   logic [5:1]  err_set_i, err_flags_o;
   logic [3:0]  delay;
   logic [7:0]  cnt, c0;
   host_req_t   host_req_i;
   int_req_t    int_req_o;
   int          fails, checks_done, i;
   logic [31:0] rst_adr [5] = '{ADR_ERR_CLR, ADR_ERR_ADDR, ADR_MISC, ADR_PIN, ADR_TUN};
   logic [31:0] rst_val [5] = '{32'h0, 32'h0, 32'h0, 32'ha7, 32'h101};
   ////////////////////////////////////////////////////////////////////////////
   dpm_err_tunnel u_dpm_err_tunnel (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .host_req_i(host_req_i), .host_busy_o(host_busy_o),
      .host_ack_o(host_ack_o), .host_rdata_o(host_rdata_o), .window_hit_o(window_hit_o),
      .int_req_o(int_req_o), .int_ack_i(int_ack_i), .int_rdata_i(int_rdata_i),
      .err_set_i(err_set_i), .err_flags_o(err_flags_o), .fast_interrupt_i(fast_interrupt_i),
      .normal_interrupt_i(normal_interrupt_i), .fast_int_pin_o(fast_int_pin_o),
      .fast_int_pin_oe_n_o(fast_int_pin_oe_n_o), .normal_int_pin_o(normal_int_pin_o),
      .normal_int_pin_oe_n_o(normal_int_pin_oe_n_o),
      .fast_int_pin_as_gpio_o(fast_int_pin_as_gpio_o),
      .normal_int_pin_as_gpio_o(normal_int_pin_as_gpio_o),
      .ready_pin_as_gpio_o(ready_pin_as_gpio_o));
   int_bus_responder u_int_bus_responder (.clk_i(clk_i), .resetn_i(resetn_i),
      .int_req_i(int_req_o), .delay_i(delay), .int_ack_o(int_ack_i), .int_rdata_o(int_rdata_i),
      .last_addr_o(last_a), .last_wdata_o(last_d), .acc_count_o(cnt));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
      @(negedge clk_i);
      reg_addr_i  = a;
      reg_wdata_i = d;
      reg_wr_i    = 1'b1;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
   endtask
   task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_rd_i   = 1'b1;
      @(negedge clk_i);
      reg_rd_i = 1'b0;
      d        = reg_rdata_o;
   endtask
   task automatic host(input logic wr, input logic [16:0] a, input logic [3:0] be,
                       input logic [31:0] d, output logic [31:0] rd, output logic hit);
      int n;
      @(negedge clk_i);
      host_req_i = '{valid: 1'b1, write: wr, addr: a, be: be, wdata: d};
      @(negedge clk_i);
      host_req_i.valid = 1'b0;
      b = host_busy_o;
      n = 0;
      while (host_ack_o !== 1'b1 && window_hit_o !== 1'b1 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
      if (n == 40) fails++;
      hit = window_hit_o;
      rd  = host_rdata_o;
   endtask
   task automatic pulse_err(input logic [5:1] e);
      @(negedge clk_i);
      err_set_i = e;
      @(negedge clk_i);
      err_set_i = 5'h00;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      #80000;
      fails++;
      results();
   end
   initial begin
      {resetn_i, reg_wr_i, reg_rd_i, fast_interrupt_i, normal_interrupt_i} = 5'h00;
      {reg_addr_i, reg_wdata_i, host_req_i, err_set_i, delay} = '0;
      repeat (12) @(negedge clk_i);
      resetn_i = 1'b1;
      repeat (3) @(negedge clk_i);
      check("gpio_rst", {29'h0, fast_int_pin_as_gpio_o, normal_int_pin_as_gpio_o,
            ready_pin_as_gpio_o}, 32'h7);
      for (i = 0; i < 5; i++) begin
         reg_rd(rst_adr[i], r);
         check("rst_val", r, rst_val[i]);
      end
      for (i = 0; i < 32; i++) begin
         reg_wr(ADR_PIN, {24'h0, i[3:0], 4'h0});
         fast_interrupt_i   = i[4];
         normal_interrupt_i = ~i[4];
         repeat (2) @(negedge clk_i);
         check("fast_pin", {29'h0, fast_int_pin_as_gpio_o, fast_int_pin_o, fast_int_pin_oe_n_o},
               {30'h0, i[2] ~^ i[4], i[3] & ~i[4]});
         check("norm_pin", {29'h0, normal_int_pin_as_gpio_o, normal_int_pin_o,
               normal_int_pin_oe_n_o}, {30'h0, i[0] ^ i[4], i[1] & i[4]});
      end
      reg_wr(ADR_PIN, 32'hff);
      reg_rd(ADR_PIN, r);
      check("pin_rsvd", r, 32'hf7);
      check("gpio_oe", {29'h0, ready_pin_as_gpio_o, fast_int_pin_oe_n_o, normal_int_pin_oe_n_o},
            32'h7);
      host(1'b0, 17'h300, 4'hf, 32'h0, r, h);
      check("win_hit", {31'h0, h}, 32'h1);
      check("win_idle", {31'h0, b}, 32'h0);
      pulse_err(5'h1f);
      reg_rd(ADR_ERR_CLR, r);
      check("flags", r, 32'h3e);
      c0 = cnt;
      host(1'b0, 17'h400, 4'hf, 32'h0, r, h);
      check("blocked", {h, r[30:0]}, 32'h0);
      check("blk_cnt", {24'h0, cnt}, {24'h0, c0});
      reg_rd(ADR_ERR_ADDR, r);
      check("err_frozen", r, 32'h300);
      reg_wr(ADR_ERR_CLR, 32'h1);
      reg_wr(ADR_ERR_CLR, 32'h4);
      check("clr_one", {27'h0, err_flags_o}, 32'h1d);
      reg_wr(ADR_ERR_CLR, 32'ha);
      err_set_i = 5'h18;
      host(1'b0, 17'h500, 4'hf, 32'h0, r, h);
      err_set_i = 5'h00;
      check("conf_hit", {31'h0, h}, 32'h1);
      reg_rd(ADR_ERR_ADDR, r);
      check("err_follow", r, 32'h500);
      reg_wr(ADR_ERR_CLR, 32'h30);
      check("clr_all", {27'h0, err_flags_o}, 32'h0);
      host(1'b0, 17'h400, 4'hf, 32'h0, r, h);
      check("retry", {31'h0, h}, 32'h1);
      reg_wr(ADR_MISC, 32'h1);
      pulse_err(5'h01);
      reg_rd(ADR_ERR_CLR, r);
      check("cor_first", r, 32'h2);
      reg_rd(ADR_ERR_CLR, r);
      check("cor_second", r, 32'h0);
      reg_wr(ADR_MISC, 32'h0);
      reg_wr(ADR_TUN, 32'h244);
      for (i = 0; i < 4; i++)
         host(1'b1, 17'(32'h27c + i), 4'(1 << i), 32'h101c101c, r, h);
      reg_rd(ADR_ITB, r);
      check("itb", r, 32'h101c101c);
      delay = 4'h3;
      host(1'b0, 17'h260, 4'hf, 32'h0, r, h);
      check("tun_addr", last_a, 32'h101c103c);
      check("tun_data", r, 32'h1f13103c);
      check("busy", {31'h0, b}, 32'h1);
      delay = 4'h0;
      host(1'b1, 17'h240, 4'hf, 32'hcafe0001, r, h);
      check("wr_addr", last_a, 32'h101c101c);
      check("wr_data", last_d, 32'hcafe0001);
      c0 = cnt;
      host(1'b1, 17'h244, 4'h3, 32'h0000beef, r, h);
      check("half_wait", {24'h0, cnt}, {24'h0, c0});
      host(1'b1, 17'h246, 4'hc, 32'h12340000, r, h);
      check("half_done", last_d, 32'h1234beef);
      check("half_addr", last_a, 32'h101c1020);
      reg_wr(ADR_TUN, 32'h4);
      host(1'b0, 17'h028, 4'hf, 32'h0, r, h);
      check("tun_first", r, 32'h1f131004);
      reg_wr(ADR_TUN, 32'h247);
      c0 = cnt;
      host(1'b1, 17'h240, 4'hf, 32'h5, r, h);
      check("wp_data", {24'h0, cnt}, {24'h0, c0});
      host(1'b1, 17'h27c, 4'hf, 32'h0, r, h);
      reg_rd(ADR_ITB, r);
      check("wp_itb", r, 32'h101c101f);
      reg_wr(ADR_ITB, 32'h40);
      host(1'b0, 17'h27c, 4'hf, 32'h0, r, h);
      check("itb_host", r, 32'h43);
      results();
   end
endmodule
`default_nettype wire
